// >>> rtl/ctc_pkg.sv
// What this block does
// - compare counter with comparators, match raises interrupt
// - three-bit field selects the counter clock source
// - external pin counts on chosen edge
// - separate interrupts for comparator a and p
// - second output pin is inverse of first
// - compare mode: a match forces high, low, toggles
// - compare a low byte write loads holding buffer only
// - compare a high byte write also copies buffer low
// - high byte read captures low byte into buffer
// - low byte read returns holding buffer
// - sixteen-bit up counter, internal or external clock
// - p checks upper byte, a checks all
// - software only clears counter via counter-on rise
// - overflow or selected match clears the counter
// - compare output, timer/counter and pwm modes
// - mode codes: 00 compare, 10 pwm, 11 timer
// - clock codes: sys/4, sys, h/16, h/64, sub, ext
// - pause bit holds counter, resumes from value
// - clear select (compare and timer modes): a match, else p/overflow
package ctc_pkg;

    localparam int ADDR_W = 8;

    ////////////////////////////////////////////////////////////////////////////
    // register byte addresses
    localparam logic [7:0] OFF_CTRL0    = 8'h00;
    localparam logic [7:0] OFF_CTRL1    = 8'h04;
    localparam logic [7:0] OFF_CNT_LO   = 8'h08;
    localparam logic [7:0] OFF_CNT_HI   = 8'h0c;
    localparam logic [7:0] OFF_CMPA_LO  = 8'h10;
    localparam logic [7:0] OFF_CMPA_HI  = 8'h14;
    localparam logic [7:0] OFF_PERIOD   = 8'h18;
    localparam logic [7:0] OFF_INT_STAT = 8'h1c;
    localparam logic [7:0] OFF_INT_MASK = 8'h20;

    ////////////////////////////////////////////////////////////////////////////
    // field codes
    localparam logic [1:0] MODE_CMP = 2'h0;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TMR = 2'h3;
    localparam logic [1:0] IO_NONE  = 2'h0;
    localparam logic [1:0] IO_LOW   = 2'h1;
    localparam logic [1:0] IO_HIGH  = 2'h2;
    localparam logic [1:0] IO_TOG   = 2'h3;
    localparam logic [1:0] IO_PWM_INACT = 2'h0;
    localparam logic [1:0] IO_PWM_ACT   = 2'h1;
    localparam logic [1:0] IO_PWM_RUN   = 2'h2;
    localparam logic [2:0] CK_SYS4     = 3'h0;
    localparam logic [2:0] CK_SYS      = 3'h1;
    localparam logic [2:0] CK_H16      = 3'h2;
    localparam logic [2:0] CK_H64      = 3'h3;
    localparam logic [2:0] CK_SUB0     = 3'h4;
    localparam logic [2:0] CK_SUB1     = 3'h5;
    localparam logic [2:0] CK_EXT_RISE = 3'h6;
    localparam logic [2:0] CK_EXT_FALL = 3'h7;
    localparam int IRQ_A = 0;
    localparam int IRQ_P = 1;

    ////////////////////////////////////////////////////////////////////////////
    // timing: high clock is pclk itself, sub clock made by divider
    localparam int CLK_HZ   = 100_000_000;
    localparam int SUB_HZ   = 32_768;
    localparam int SUB_DIV  = CLK_HZ / SUB_HZ;
    localparam int DIV_SYS4 = 4;
    localparam int DIV_H16  = 16;
    localparam int DIV_H64  = 64;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic       pause;
        logic [2:0] cksel;
        logic       on;
        logic [2:0] rsvd;
    } ctc_ctl0_t;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] io;
        logic       oc;
        logic       pol;
        logic       dpx;
        logic       clr_sel;
    } ctc_ctl1_t;

    typedef struct packed {
        ctc_ctl0_t   ctl0;
        ctc_ctl1_t   ctl1;
        logic [15:0] compare_a_value;
        logic [7:0]  compare_p_value;
        logic [15:0] count;
        logic [7:0]  hold;
        logic [1:0]  stat;
        logic [1:0]  mask;
        logic [5:0]  presc;
        logic [11:0] subcnt;
        logic        ext_s1;
        logic        ext_s2;
        logic        ext_s3;
        logic        out_lvl;
        logic        pin;
        logic        irq;
        logic [31:0] prdata;
        logic        pslverr;
    } ctc_state_t;

    localparam ctc_state_t STATE_RST = '0;

endpackage

// >>> rtl/ctc_timer.sv
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module ctc_timer #(
    parameter int SUB_DIV = ctc_pkg::SUB_DIV
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [ctc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       ext_clock_pin,
    output logic                            timer_output_pin,
    output logic                            inverted_output_pin,
    output logic                            irq
);

    ctc_pkg::ctc_state_t s;
    ctc_pkg::ctc_state_t next_s;

    logic        setup;
    logic        wr_acc;
    logic        rd_setup;
    logic        tick;
    logic        cnt_en;
    logic        evt_a;
    logic        evt_p;
    logic        clr;
    logic        on_rise;
    logic        duty;
    logic        mapped;
    logic [31:0] rd_mux;
    logic [7:0]  wbyte;

    ////////////////////////////////////////////////////////////////////////////
    // combinational next state
    always_comb begin
        next_s  = s;
        setup   = psel && !penable;
        wr_acc  = psel && penable && pwrite;
        rd_setup = psel && !penable && !pwrite;
        wbyte   = pwdata[7:0];
        on_rise = 1'b0;
        duty    = 1'b0;

        // prescaler and sub clock divider run free
        next_s.presc = s.presc + 6'h01;
        if (s.subcnt == 12'(SUB_DIV - 1)) begin
            next_s.subcnt = 12'h000;
        end else begin
            next_s.subcnt = s.subcnt + 12'h001;
        end

        // pin synchroniser, edge seen between stages two and three
        next_s.ext_s1 = ext_clock_pin;
        next_s.ext_s2 = s.ext_s1;
        next_s.ext_s3 = s.ext_s2;

        unique case (s.ctl0.cksel)
            ctc_pkg::CK_SYS4: tick = s.presc[1:0] == 2'(ctc_pkg::DIV_SYS4 - 1);
            ctc_pkg::CK_SYS:  tick = 1'b1;
            ctc_pkg::CK_H16:  tick = s.presc[3:0] == 4'(ctc_pkg::DIV_H16 - 1);
            ctc_pkg::CK_H64:  tick = s.presc == 6'(ctc_pkg::DIV_H64 - 1);
            ctc_pkg::CK_SUB0,
            ctc_pkg::CK_SUB1: tick = s.subcnt == 12'(SUB_DIV - 1);
            ctc_pkg::CK_EXT_RISE: tick = s.ext_s2 && !s.ext_s3;
            ctc_pkg::CK_EXT_FALL: tick = !s.ext_s2 && s.ext_s3;
        endcase

        // events are taken on the count edge that leaves the match value
        cnt_en = s.ctl0.on && !s.ctl0.pause && tick;
        evt_a  = cnt_en && (s.count == s.compare_a_value);
        // p matches at the last count of its upper byte; zero means overflow
        evt_p  = cnt_en && (s.count == {s.compare_p_value - 8'h01, 8'hff});

        if (s.ctl1.mode == ctc_pkg::MODE_PWM) begin
            clr = s.ctl1.dpx ? evt_a : evt_p;
        end else begin
            clr = s.ctl1.clr_sel ? evt_a : evt_p;
        end

        if (cnt_en) begin
            next_s.count = clr ? 16'h0000 : s.count + 16'h0001;
        end

        // output level per mode
        unique case (s.ctl1.mode)
            ctc_pkg::MODE_CMP: begin
                if (evt_a) begin
                    unique case (s.ctl1.io)
                        ctc_pkg::IO_NONE: next_s.out_lvl = s.out_lvl;
                        ctc_pkg::IO_LOW:  next_s.out_lvl = 1'b0;
                        ctc_pkg::IO_HIGH: next_s.out_lvl = 1'b1;
                        ctc_pkg::IO_TOG:  next_s.out_lvl = !s.out_lvl;
                    endcase
                end
            end
            ctc_pkg::MODE_PWM: begin
                duty = s.ctl1.dpx ? (s.count[15:8] < s.compare_p_value) : (s.count < s.compare_a_value);
                unique case (s.ctl1.io)
                    ctc_pkg::IO_PWM_ACT: next_s.out_lvl = s.ctl1.oc;
                    ctc_pkg::IO_PWM_RUN: next_s.out_lvl = duty ? s.ctl1.oc : !s.ctl1.oc;
                    default:             next_s.out_lvl = !s.ctl1.oc;
                endcase
            end
            // timer mode and the undefined code leave the pin parked
            default: next_s.out_lvl = s.out_lvl;
        endcase

        // sticky interrupt status, set beats a same-cycle clear
        next_s.stat[ctc_pkg::IRQ_A] = s.stat[ctc_pkg::IRQ_A] || evt_a;
        next_s.stat[ctc_pkg::IRQ_P] = s.stat[ctc_pkg::IRQ_P] || evt_p;

        // read mux, sampled in setup so prdata is a flop in access
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            ctc_pkg::OFF_CTRL0:    rd_mux[7:0] = {s.ctl0[7:3], 3'h0};
            ctc_pkg::OFF_CTRL1:    rd_mux[7:0] = s.ctl1;
            ctc_pkg::OFF_CNT_LO,
            ctc_pkg::OFF_CMPA_LO:  rd_mux[7:0] = s.hold;
            ctc_pkg::OFF_CNT_HI:   rd_mux[7:0] = s.count[15:8];
            ctc_pkg::OFF_CMPA_HI:  rd_mux[7:0] = s.compare_a_value[15:8];
            ctc_pkg::OFF_PERIOD:   rd_mux[7:0] = s.compare_p_value;
            ctc_pkg::OFF_INT_STAT: rd_mux[1:0] = s.stat;
            ctc_pkg::OFF_INT_MASK: rd_mux[1:0] = s.mask;
            default:               mapped = 1'b0;
        endcase
        if (setup) begin
            next_s.prdata  = pwrite ? 32'h0000_0000 : rd_mux;
            next_s.pslverr = !mapped;
        end

        // high byte read latches its low byte on the edge that loads prdata,
        // so a carry between setup and access cannot tear the pair
        if (rd_setup && paddr == ctc_pkg::OFF_CNT_HI) begin
            next_s.hold = s.count[7:0];
        end
        if (rd_setup && paddr == ctc_pkg::OFF_CMPA_HI) begin
            next_s.hold = s.compare_a_value[7:0];
        end

        if (wr_acc) begin
            unique case (paddr)
                ctc_pkg::OFF_CTRL0: begin
                    next_s.ctl0      = wbyte;
                    next_s.ctl0.rsvd = 3'h0;
                    on_rise          = wbyte[3] && !s.ctl0.on;
                end
                ctc_pkg::OFF_CTRL1:    next_s.ctl1 = wbyte;
                // low byte only reaches the holding buffer
                ctc_pkg::OFF_CMPA_LO:  next_s.hold = wbyte;
                ctc_pkg::OFF_CMPA_HI:  next_s.compare_a_value = {wbyte, s.hold};
                ctc_pkg::OFF_PERIOD:   next_s.compare_p_value = wbyte;
                ctc_pkg::OFF_INT_STAT: next_s.stat = next_s.stat & ~(pwdata[1:0] & ~{evt_p, evt_a});
                ctc_pkg::OFF_INT_MASK: next_s.mask = pwdata[1:0];
                // counter is read only; other addresses ignore writes
                default: ;
            endcase
        end

        // only a counter-on rise lets software touch the counter
        if (on_rise) begin
            next_s.count = 16'h0000;
            if (s.ctl1.mode == ctc_pkg::MODE_CMP || s.ctl1.mode == ctc_pkg::MODE_PWM) begin
                next_s.out_lvl = s.ctl1.oc;
            end
        end

        next_s.pin = next_s.out_lvl ^ next_s.ctl1.pol;
        next_s.irq = |(next_s.stat & next_s.mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= ctc_pkg::STATE_RST;
        end else begin
            s <= next_s;
        end
    end

    // no wait states; error answer only on unmapped addresses
    assign pready              = 1'b1;
    assign prdata              = s.prdata;
    assign pslverr             = s.pslverr;
    assign irq                 = s.irq;
    assign timer_output_pin    = s.pin;
    assign inverted_output_pin = !s.pin;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    hold_write_a: assert property (
        wr_acc && paddr == ctc_pkg::OFF_CMPA_LO |=> s.compare_a_value == $past(s.compare_a_value)
            && s.hold == $past(pwdata[7:0]))
        else $error("low byte write changed compare a");

    high_write_a: assert property (
        wr_acc && paddr == ctc_pkg::OFF_CMPA_HI
            |=> s.compare_a_value == {$past(pwdata[7:0]), $past(s.hold)})
        else $error("high byte write did not merge buffer");

    hi_read_cap_a: assert property (
        rd_setup && paddr == ctc_pkg::OFF_CNT_HI |=> s.hold == $past(s.count[7:0])
            && prdata[7:0] == $past(s.count[15:8]))
        else $error("counter high read did not capture low");

    lo_read_a: assert property (
        setup && !pwrite && paddr == ctc_pkg::OFF_CMPA_LO
            |=> prdata == {24'h000000, $past(s.hold)})
        else $error("low byte read not from buffer");

    con_clear_a: assert property (
        wr_acc && paddr == ctc_pkg::OFF_CTRL0 && pwdata[3] && !s.ctl0.on
            |=> s.count == 16'h0000)
        else $error("counter not cleared on counter-on rise");

    pause_hold_a: assert property (
        (s.ctl0.pause && !wr_acc) [*2] |-> $stable(s.count))
        else $error("counter moved while paused");

    irq_a_set_a: assert property (
        evt_a |=> s.stat[ctc_pkg::IRQ_A] && (!s.mask[ctc_pkg::IRQ_A] || s.irq))
        else $error("comparator a event lost");

    clr_sel_a: assert property (
        evt_a && s.ctl1.clr_sel && s.ctl1.mode == ctc_pkg::MODE_CMP && !wr_acc
            |=> s.count == 16'h0000)
        else $error("counter not cleared on a match");

    toggle_out_a: assert property (
        evt_a && s.ctl1.mode == ctc_pkg::MODE_CMP && s.ctl1.io == ctc_pkg::IO_TOG
            && !wr_acc |=> s.out_lvl != $past(s.out_lvl))
        else $error("compare toggle did not toggle");

    ext_edge_a: assert property (
        s.ctl0.on && !s.ctl0.pause && s.ctl0.cksel == ctc_pkg::CK_EXT_RISE
            && s.ext_s2 && !s.ext_s3 && !clr && !wr_acc
            |=> s.count == $past(s.count) + 16'h0001)
        else $error("rising pin edge not counted");

    ext_fall_a: assert property (
        s.ctl0.on && !s.ctl0.pause && s.ctl0.cksel == ctc_pkg::CK_EXT_FALL
            && !s.ext_s2 && s.ext_s3 && !clr && !wr_acc
            |=> s.count == $past(s.count) + 16'h0001)
        else $error("falling pin edge not counted");

    irq_p_set_a: assert property (
        evt_p |=> s.stat[ctc_pkg::IRQ_P])
        else $error("comparator p event lost");

    irq_level_a: assert property (
        irq == |(s.stat & s.mask))
        else $error("interrupt level disagrees with status");

    inv_pin_a: assert property (
        inverted_output_pin != timer_output_pin)
        else $error("output pins not complementary");

    p_clear_a: assert property (
        evt_p && !s.ctl1.clr_sel && s.ctl1.mode != ctc_pkg::MODE_PWM && !wr_acc
            |=> s.count == 16'h0000)
        else $error("counter not cleared on p match");

    overflow_a: assert property (
        cnt_en && s.count == 16'hffff && s.compare_p_value == 8'h00 && !s.ctl1.clr_sel
            && s.ctl1.mode != ctc_pkg::MODE_PWM && !wr_acc |=> s.count == 16'h0000)
        else $error("overflow did not clear counter");

    count_up_a: assert property (
        cnt_en && !clr && !wr_acc |=> s.count == $past(s.count) + 16'h0001)
        else $error("counter did not advance on tick");

    off_hold_a: assert property (
        !s.ctl0.on && !wr_acc |=> $stable(s.count))
        else $error("counter moved while off");

    cmp_low_a: assert property (
        evt_a && s.ctl1.mode == ctc_pkg::MODE_CMP && s.ctl1.io == ctc_pkg::IO_LOW
            && !wr_acc |=> !s.out_lvl)
        else $error("compare low did not drive low");

    pwm_act_a: assert property (
        s.ctl1.mode == ctc_pkg::MODE_PWM && s.ctl1.io == ctc_pkg::IO_PWM_ACT
            && !wr_acc |=> s.out_lvl == $past(s.ctl1.oc))
        else $error("pwm active state not held");

    cov_a_match_c:  cover property (evt_a && s.ctl1.clr_sel);
    cov_overflow_c: cover property (evt_p && s.compare_p_value == 8'h00);
    cov_pwm_c:      cover property (s.ctl1.mode == ctc_pkg::MODE_PWM && $rose(s.pin));
    cov_irq_c:      cover property ($rose(irq));

endmodule
`default_nettype wire

// >>> verification/ctc_timer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module ctc_timer_tb_top;
    // short sub clock divider keeps the run brief
    localparam int SUBD = 5;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic        ext     = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tpin;
    logic        ipin;
    logic        irq;
    logic        serr;
    int          err_total = 0;
    int          tests_run = 0;

    always #5 pclk = ~pclk;

    ctc_timer #(.SUB_DIV(SUBD)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_clock_pin(ext), .timer_output_pin(tpin), .inverted_output_pin(ipin), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("mismatches %0d, comparisons %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; idle edge first so no signal is driven twice in a step
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            give_verdict();
        end
        q = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, q);
    endtask

    // high byte first so the pair is one snapshot
    task automatic rdcnt(output logic [15:0] c);
        logic [31:0] h;
        logic [31:0] l;
        rd(ctc_pkg::OFF_CNT_HI, h);
        rd(ctc_pkg::OFF_CNT_LO, l);
        c = {h[7:0], l[7:0]};
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [31:0] q;
        for (int i = 0; i < 9; i++) begin
            rd(8'(i * 4), q);
            chk(q, 32'h0);
        end
        chk(32'({tpin, ipin, irq}), 32'h2);
        rd(8'h24, q);
        chk(32'({serr, q[7:0]}), 32'h100);
    endtask

    task automatic t_buf;
        logic [31:0] q;
        wr(ctc_pkg::OFF_CMPA_LO, 32'h34);
        rd(ctc_pkg::OFF_CMPA_HI, q);
        rd(ctc_pkg::OFF_CMPA_LO, q);
        chk(q, 32'h0);
        wr(ctc_pkg::OFF_CMPA_LO, 32'h34);
        wr(ctc_pkg::OFF_CMPA_HI, 32'h12);
        rd(ctc_pkg::OFF_CMPA_HI, q);
        chk(q, 32'h12);
        wr(ctc_pkg::OFF_CMPA_LO, 32'h56);
        rd(ctc_pkg::OFF_CMPA_LO, q);
        chk(q, 32'h56);
        rd(ctc_pkg::OFF_CMPA_HI, q);
        rd(ctc_pkg::OFF_CMPA_LO, q);
        chk(q, 32'h34);
    endtask

    task automatic t_clk;
        int          div[6] = '{4, 1, 16, 64, SUBD, SUBD};
        int          e;
        logic [15:0] c;
        logic [15:0] c2;
        wr(ctc_pkg::OFF_CTRL1, 32'h0);
        wr(ctc_pkg::OFF_PERIOD, 32'h0);
        for (int s = 0; s < 6; s++) begin
            wr(ctc_pkg::OFF_CTRL0, 32'(s * 16));
            wr(ctc_pkg::OFF_CTRL0, 32'(s * 16 + 8));
            cyc(600);
            wr(ctc_pkg::OFF_CTRL0, 32'(s * 16 + 8'h88));
            rdcnt(c);
            e = 602 / div[s];
            chk(32'(c > e - 3 && c < e + 3), 32'h1);
            cyc(50);
            rdcnt(c2);
            chk(32'(c2), 32'(c));
        end
        wr(ctc_pkg::OFF_CTRL0, 32'h58);
        cyc(50);
        rdcnt(c2);
        chk(32'(c2 >= c + 9 && c2 <= c + 12), 32'h1);
        wr(ctc_pkg::OFF_CNT_HI, 32'hff);
        wr(ctc_pkg::OFF_CTRL0, 32'h50);
        wr(ctc_pkg::OFF_CTRL0, 32'hd8);
        rdcnt(c);
        chk(32'(c), 32'h0);
    endtask

    // distinct pulse counts per edge code; whole pulses give a swapped edge the same count
    task automatic t_ext;
        logic [15:0] c;
        for (int k = 6; k < 8; k++) begin
            wr(ctc_pkg::OFF_CTRL0, 32'(k * 16));
            wr(ctc_pkg::OFF_CTRL0, 32'(k * 16 + 8));
            for (int p = 0; p < k - 1; p++) begin
                ext <= 1'b1;
                cyc(4);
                ext <= 1'b0;
                cyc(4);
            end
            cyc(4);
            rdcnt(c);
            chk(32'(c), 32'(k - 1));
        end
    endtask

    task automatic t_irq;
        logic [31:0] q;
        logic [15:0] c;
        wr(ctc_pkg::OFF_CTRL0, 32'h10);
        wr(ctc_pkg::OFF_CTRL1, 32'h1);
        wr(ctc_pkg::OFF_CMPA_LO, 32'h2);
        wr(ctc_pkg::OFF_CMPA_HI, 32'h0);
        wr(ctc_pkg::OFF_INT_MASK, 32'h3);
        wr(ctc_pkg::OFF_INT_STAT, 32'h3);
        wr(ctc_pkg::OFF_CTRL0, 32'h18);
        for (int i = 0; i < 4; i++) begin
            rdcnt(c);
            chk(32'(c <= 2), 32'h1);
        end
        rd(ctc_pkg::OFF_INT_STAT, q);
        chk({q[30:0], irq}, 32'h3);
        wr(ctc_pkg::OFF_CTRL0, 32'h10);
        wr(ctc_pkg::OFF_INT_STAT, 32'h1);
        cyc(2);
        rd(ctc_pkg::OFF_INT_STAT, q);
        chk({q[30:0], irq}, 32'h0);
        wr(ctc_pkg::OFF_CTRL1, 32'h0);
        wr(ctc_pkg::OFF_PERIOD, 32'h1);
        wr(ctc_pkg::OFF_CMPA_LO, 32'h10);
        wr(ctc_pkg::OFF_CMPA_HI, 32'h0);
        wr(ctc_pkg::OFF_INT_MASK, 32'h1);
        wr(ctc_pkg::OFF_CTRL0, 32'h18);
        cyc(600);
        for (int i = 0; i < 4; i++) begin
            rdcnt(c);
            chk(32'(c[15:8]), 32'h0);
        end
        rd(ctc_pkg::OFF_INT_STAT, q);
        chk(q, 32'h3);
        wr(ctc_pkg::OFF_CTRL0, 32'h10);
        wr(ctc_pkg::OFF_INT_STAT, 32'h1);
        cyc(2);
        chk(32'(irq), 32'h0);
        wr(ctc_pkg::OFF_INT_MASK, 32'h2);
        cyc(2);
        chk(32'(irq), 32'h1);
    endtask

    // io codes none, low, high, toggle; initial level differs from target for low, high and toggle
    task automatic t_out;
        logic oc[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
        logic ex[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
        int   n;
        wr(ctc_pkg::OFF_PERIOD, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(ctc_pkg::OFF_CTRL0, 32'h10);
            wr(ctc_pkg::OFF_CTRL1, 32'({2'b00, 2'(i), oc[i], 3'b000}));
            wr(ctc_pkg::OFF_CTRL0, 32'h18);
            cyc(2);
            chk(32'({tpin, ipin}), 32'({oc[i], ~oc[i]}));
            cyc(40);
            chk(32'({tpin, ipin}), 32'({ex[i], ~ex[i]}));
        end
        wr(ctc_pkg::OFF_CTRL0, 32'h10);
        wr(ctc_pkg::OFF_PERIOD, 32'h1);
        wr(ctc_pkg::OFF_CTRL1, 32'ha8);
        wr(ctc_pkg::OFF_CTRL0, 32'h18);
        n = 0;
        repeat (512) begin
            @(posedge pclk);
            n += int'(tpin);
        end
        chk(32'(n >= 30 && n <= 34), 32'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_buf();
        t_clk();
        t_ext();
        t_irq();
        t_out();
        give_verdict();
    end
endmodule
`default_nettype wire
